// [gsd_ctrl.sv]
// Memory controller end: runs the power-up sequence, mode rewrites and single bursts.
// Assumes a plain register port from software and the device on the other side of the link.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
// What the controller and device ends do
// R1: Hold clock enable and reset low at power-up
// R2: Reset low at least 100 us
// R3: Clock enable at reset rise picks termination
// R4: Reset low, select high keeps device quiet
// R5: Wait 200 us before any command
// R6: No-op, raise reset and enable, precharge all
// R7: Dummy mode write with fixed pattern
// R8: Extended mode write, bank 01, enables DLL
// R9: Mode write, bank 00, with DLL reset
// R10: Allow 20K clocks for DLL lock
// R11: Precharge all, then two auto refreshes
// R12: Mode write is all-low command, enable high
// R13: Six clocks after a mode write
// R14: Rewrite mode only with all banks idle
// R15: Program mode after extended mode setting
// R16: Device decodes mode fields by bit position
// R17: Burst length four only, no reserved codes
// R18: Bursts wrap inside aligned four-column block
// R19: Burst type must be sequential
// R20: Column bits A0 A1 zero, order 0-3
// R21: Device updates impedance on refresh and idle no-ops
// R22: Impedance optimal 20 us after clock
// R23: Data termination quarter or half of reference
// R24: DLL reset bit self-clears; no power-down soon
module gsd_ctrl #(
	parameter int LINK_HALF    = gsd_pkg::LINK_HALF,
	parameter int POWER_CYC    = gsd_pkg::POWER_CYC,
	parameter int DLL_LOCK_CLK = gsd_pkg::DLL_LOCK_CLK
) (
	// System
	input  wire logic        clk,
	input  wire logic        rstn,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Link
	gsd_link_if.ctrl         link
);
	localparam logic [3:0] ST_PREALL1 = 4'h0;
	localparam logic [3:0] ST_DUMMY   = 4'h1;
	localparam logic [3:0] ST_EXT     = 4'h2;
	localparam logic [3:0] ST_MODE    = 4'h3;
	localparam logic [3:0] ST_PREALL2 = 4'h4;
	localparam logic [3:0] ST_REF1    = 4'h5;
	localparam logic [3:0] ST_REF2    = 4'h6;
	localparam logic [3:0] ST_REWRITE = 4'h7;
	localparam logic [3:0] ST_ACCESS  = 4'h8;

	gsd_pkg::gsd_state_t state;
	logic [7:0]          div;
	logic                ck;
	logic [15:0]         cnt;
	logic [3:0]          step;
	logic [3:0]          cmd;
	logic [1:0]          bank;
	logic [11:0]         addr;
	logic                reset_pin_n;
	logic                cke;
	logic                term_full;
	logic [11:0]         mode_reg;
	logic [11:0]         ext_reg;
	logic [12:0]         acc_reg;
	logic                init_done;
	logic [15:0]         imp_cnt;
	logic                imp_ok;

	// Link clock divider; commands change on the falling edge
	wire [7:0] div_last = 8'(2 * LINK_HALF - 1);
	wire [7:0] next_div = (div == div_last) ? 8'h00 : div + 8'h01;
	wire       fall     = (div == 8'(LINK_HALF - 1));

	// Register decode
	wire wr_ctrl   = reg_wr & (reg_addr == gsd_pkg::REG_CTRL);
	wire wr_mode   = reg_wr & (reg_addr == gsd_pkg::REG_MODE);
	wire wr_ext    = reg_wr & (reg_addr == gsd_pkg::REG_EXT);
	wire wr_access = reg_wr & (reg_addr == gsd_pkg::REG_ACCESS);
	wire start     = wr_ctrl & reg_wdata[gsd_pkg::CTRL_START];
	wire rewrite   = wr_ctrl & reg_wdata[gsd_pkg::CTRL_REWRITE];

	// Mode word with burst length and type forced to the legal values
	wire [11:0] mode_word = {mode_reg[11:4], 1'b0, gsd_pkg::BL4_CODE}; // R17 R19
	wire [11:0] dll_mask  = 12'(1 << gsd_pkg::DLL_RST_BIT);
	wire [11:0] prea_mask = 12'(1 << gsd_pkg::PRECHARGE_ALL_CMD_BIT);
	wire [11:0] col_word  = {4'h0, acc_reg[7:2], 2'b00}; // R20

	// Step table: command, bank and address for each step
	function automatic logic [17:0] step_word(input logic [3:0] s, input logic [11:0] mw,
	                                          input logic [11:0] ew, input logic [12:0] acc,
	                                          input logic [11:0] cw);
		logic [3:0] acc_cmd;
		acc_cmd = acc[gsd_pkg::ACC_WRITE] ? gsd_pkg::WRITE_CMD : gsd_pkg::READ_CMD;
		case (s)
			ST_PREALL1: step_word = {gsd_pkg::PRECHARGE_ALL_CMD, 2'h0, prea_mask}; // R6
			ST_DUMMY:   step_word = {gsd_pkg::MODE_REGISTER_WRITE_CMD, gsd_pkg::DUMMY_MODE}; // R7
			ST_EXT:     step_word = {gsd_pkg::MODE_REGISTER_WRITE_CMD, gsd_pkg::BANK_EXT, ew}; // R8
			ST_MODE:    step_word = {gsd_pkg::MODE_REGISTER_WRITE_CMD, gsd_pkg::BANK_MODE,
			                         mw | dll_mask}; // R9 R15
			ST_PREALL2: step_word = {gsd_pkg::PRECHARGE_ALL_CMD, 2'h0, prea_mask}; // R11
			ST_REF1:    step_word = {gsd_pkg::AUTO_REFRESH_CMD, 2'h0, 12'h000}; // R11
			ST_REF2:    step_word = {gsd_pkg::AUTO_REFRESH_CMD, 2'h0, 12'h000}; // R11
			ST_REWRITE: step_word = {gsd_pkg::MODE_REGISTER_WRITE_CMD, gsd_pkg::BANK_MODE, mw};
			ST_ACCESS:  step_word = {acc_cmd, acc[9:8], cw};
			default:    step_word = {gsd_pkg::NOP_CMD, 2'h0, 12'h000};
		endcase
	endfunction

	wire [17:0] cur_step = step_word(step, mode_word, ext_reg, acc_reg, col_word);
	wire        cnt_done_power = (cnt >= 16'(POWER_CYC - 1)); // R2 R5
	wire        gap_done       = (cnt == 16'(gsd_pkg::MODE_WRITE_CLK - 1)); // R13
	wire        lock_done      = (cnt == 16'(DLL_LOCK_CLK - 1)); // R10
	wire        last_init      = (step == ST_REF2);
	wire        after_dll      = (step == ST_MODE);
	wire        is_ready       = (state == gsd_pkg::GSD_READY);

	assign link.ck                 = ck;
	assign link.device_reset_pin_n = reset_pin_n;
	assign link.cke                = cke;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd; // R12
	assign link.bank_select        = bank;
	assign link.addr               = addr;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			div <= 8'h00;
			ck  <= 1'b0;
		end else begin
			div <= next_div;
			ck  <= (next_div < 8'(LINK_HALF));
		end
	end

	// Impedance settle time since the link clock started
	always_ff @(posedge clk) begin
		if (!rstn) begin
			imp_cnt <= 16'h0000;
			imp_ok  <= 1'b0;
		end else if (!imp_ok) begin
			imp_cnt <= imp_cnt + 16'h0001;
			imp_ok  <= (imp_cnt == 16'(gsd_pkg::IMP_CYC - 1)); // R22
		end
	end

	// Software registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			term_full <= 1'b0;
			mode_reg  <= 12'h000;
			ext_reg   <= 12'h000;
			acc_reg   <= 13'h0000;
		end else begin
			if (wr_ctrl) begin
				term_full <= reg_wdata[gsd_pkg::CTRL_TERM];
			end
			if (wr_mode) begin
				mode_reg <= reg_wdata[11:0];
			end
			if (wr_ext) begin
				ext_reg <= reg_wdata[11:0];
			end
			if (wr_access && is_ready) begin
				acc_reg <= reg_wdata[12:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				gsd_pkg::REG_CTRL:   reg_rdata <= {30'h0, term_full, 1'b0};
				gsd_pkg::REG_MODE:   reg_rdata <= {20'h0, mode_reg};
				gsd_pkg::REG_EXT:    reg_rdata <= {20'h0, ext_reg};
				gsd_pkg::REG_STATUS: reg_rdata <= {20'h0, state, 1'b0, imp_ok, init_done,
				                                   ~is_ready & (state != gsd_pkg::GSD_IDLE)};
				gsd_pkg::REG_ACCESS: reg_rdata <= {19'h0, acc_reg};
				default:             reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Sequencer
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state       <= gsd_pkg::GSD_IDLE;
			cnt         <= 16'h0000;
			step        <= ST_PREALL1;
			cmd         <= gsd_pkg::DESELECT_CMD; // R4
			bank        <= 2'h0;
			addr        <= 12'h000;
			reset_pin_n <= 1'b0; // R1
			cke         <= 1'b0; // R1
			init_done   <= 1'b0;
		end else begin
			case (state)
				gsd_pkg::GSD_IDLE: begin
					if (start) begin
						state       <= gsd_pkg::GSD_POWER;
						cnt         <= 16'h0000;
						reset_pin_n <= 1'b0; // R1
						cke         <= 1'b0; // R1
						cmd         <= gsd_pkg::DESELECT_CMD; // R4
						init_done   <= 1'b0;
					end
				end
				gsd_pkg::GSD_POWER: begin
					if (!cnt_done_power) begin
						cnt <= cnt + 16'h0001;
					end else if (fall) begin
						cmd   <= gsd_pkg::NOP_CMD; // R6
						state <= gsd_pkg::GSD_RELEASE;
					end
				end
				gsd_pkg::GSD_RELEASE: begin
					if (fall) begin
						reset_pin_n <= 1'b1; // R6
						cke         <= term_full; // R3
						state       <= gsd_pkg::GSD_CKE_UP;
					end
				end
				gsd_pkg::GSD_CKE_UP: begin
					if (fall) begin
						cke   <= 1'b1; // R6
						step  <= ST_PREALL1;
						state <= gsd_pkg::GSD_ISSUE;
					end
				end
				gsd_pkg::GSD_ISSUE: begin
					if (fall) begin
						{cmd, bank, addr} <= cur_step;
						cnt               <= 16'h0000;
						state             <= gsd_pkg::GSD_GAP;
					end
				end
				gsd_pkg::GSD_GAP: begin
					if (fall) begin
						cmd  <= gsd_pkg::NOP_CMD;
						bank <= 2'h0;
						addr <= 12'h000;
						cnt  <= cnt + 16'h0001;
						if (gap_done) begin // R13
							cnt <= 16'h0000;
							if (after_dll) begin
								state <= gsd_pkg::GSD_LOCK; // R10
							end else if (last_init || step > ST_REF2) begin
								init_done <= 1'b1;
								state     <= gsd_pkg::GSD_READY;
							end else begin
								step  <= step + 4'h1;
								state <= gsd_pkg::GSD_ISSUE;
							end
						end
					end
				end
				gsd_pkg::GSD_LOCK: begin
					if (fall) begin
						cnt <= cnt + 16'h0001;
						if (lock_done) begin // R10
							step  <= ST_PREALL2;
							state <= gsd_pkg::GSD_ISSUE;
						end
					end
				end
				gsd_pkg::GSD_READY: begin
					// No bank is ever opened, so all banks are idle here
					if (rewrite) begin
						step  <= ST_REWRITE; // R14
						state <= gsd_pkg::GSD_ISSUE;
					end else if (wr_access) begin
						step  <= ST_ACCESS;
						state <= gsd_pkg::GSD_ISSUE;
					end else if (start) begin
						state       <= gsd_pkg::GSD_POWER;
						cnt         <= 16'h0000;
						reset_pin_n <= 1'b0;
						cke         <= 1'b0;
						cmd         <= gsd_pkg::DESELECT_CMD;
						init_done   <= 1'b0;
					end
				end
				default: begin
					state <= gsd_pkg::GSD_IDLE;
				end
			endcase
		end
	end
endmodule

// [gsd_dev.sv]
// Memory device end: samples the link on its own clock, decodes mode writes and bursts.
// Assumes the link pins change well away from the rising edge of the link clock.
`timescale 1ns/100ps
module gsd_dev #(
	parameter int DLL_SELF_CLEAR_CLK = gsd_pkg::DLL_SELF_CLEAR_CLK
) (
	// System
	input  wire logic        clk,
	input  wire logic        rstn,
	// Link
	gsd_link_if.dev          link,
	// Mode state
	output logic [11:0]      mode_value,
	output logic [11:0]      ext_value,
	output logic [2:0]       burst_len_code,
	output logic [2:0]       read_lat,
	output logic [2:0]       write_lat,
	output logic             test_mode,
	output logic             dll_reset_busy,
	output logic             mode_illegal,
	output logic             dll_on,
	output logic             odt_on,
	output logic             addr_term_full,
	output logic             dq_term_quarter,
	// Activity
	output logic             imp_update,
	output logic             col_valid,
	output logic             col_is_write,
	output logic [7:0]       col_addr
);
	localparam int PW = 21;

	logic [PW-1:0] sync1;
	logic [PW-1:0] sync2;
	logic          ck_d;
	logic          rst_d;
	logic [15:0]   dll_cnt;
	logic [1:0]    beats_left;
	logic [5:0]    col_base;
	logic [1:0]    col_off;
	logic          burst_on;

	wire        s_ck   = sync2[20];
	wire        s_rstn = sync2[19];
	wire        s_cke  = sync2[18];
	wire [3:0]  s_cmd  = sync2[17:14];
	wire [1:0]  s_bank = sync2[13:12];
	wire [11:0] s_addr = sync2[11:0];
	wire [1:0]  bank   = s_bank;
	wire        rise     = s_ck & ~ck_d;
	wire        rst_rise = s_rstn & ~rst_d;
	wire        live     = rise & s_rstn & s_cke;
	wire        is_mode  = live & (s_cmd == gsd_pkg::MODE_REGISTER_WRITE_CMD);
	wire        is_rd    = live & (s_cmd == gsd_pkg::READ_CMD);
	wire        is_wr    = live & (s_cmd == gsd_pkg::WRITE_CMD);
	wire        is_ref   = live & (s_cmd == gsd_pkg::AUTO_REFRESH_CMD);
	wire        is_nop   = live & (s_cmd == gsd_pkg::NOP_CMD);
	wire        read_on  = burst_on & ~col_is_write;
	wire        dll_set  = is_mode & (bank == gsd_pkg::BANK_MODE) & s_addr[gsd_pkg::DLL_RST_BIT];

	// Field decode of the stored mode and extended mode words
	assign burst_len_code  = mode_value[gsd_pkg::BL_LSB+:3]; // R16
	assign read_lat        = mode_value[gsd_pkg::RL_LSB+:3]; // R16
	assign test_mode       = mode_value[gsd_pkg::TEST_BIT]; // R16
	assign dll_reset_busy  = mode_value[gsd_pkg::DLL_RST_BIT]; // R16
	assign write_lat       = mode_value[gsd_pkg::WL_LSB+:3]; // R16
	assign mode_illegal    = (burst_len_code != gsd_pkg::BL4_CODE) |
	                         mode_value[gsd_pkg::BURST_TYPE_BIT]; // R17 R19
	assign dq_term_quarter = ext_value[gsd_pkg::EXT_DT_BIT]; // R23
	// No read data path here; the data bus is never driven
	assign link.dq_oe      = 1'b0; // R4

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync1 <= '0;
			sync2 <= '0;
			ck_d  <= 1'b0;
			rst_d <= 1'b0;
		end else begin
			sync1 <= {link.ck, link.device_reset_pin_n, link.cke, link.cs_n, link.ras_n,
			          link.cas_n, link.we_n, link.bank_select, link.addr};
			sync2 <= sync1;
			ck_d  <= s_ck;
			rst_d <= s_rstn;
		end
	end

	// Termination choice caught at reset release
	always_ff @(posedge clk) begin
		if (!rstn) begin
			addr_term_full <= 1'b0;
		end else if (rst_rise) begin
			addr_term_full <= s_cke; // R3
		end
	end

	// Mode, extended mode and DLL state
	always_ff @(posedge clk) begin
		if (!rstn || !s_rstn) begin
			mode_value <= '0; // R15
			ext_value  <= '0;
			dll_on     <= 1'b0; // R4
			odt_on     <= 1'b0; // R4
			dll_cnt    <= '0;
		end else begin
			if (rise && dll_cnt != 16'h0000) begin
				dll_cnt <= dll_cnt - 16'h0001;
				if (dll_cnt == 16'h0001) begin
					mode_value[gsd_pkg::DLL_RST_BIT] <= 1'b0; // R24
				end
			end
			if (is_mode && bank == gsd_pkg::BANK_MODE) begin
				mode_value <= s_addr; // R12
			end
			if (dll_set) begin
				dll_cnt <= 16'(DLL_SELF_CLEAR_CLK); // R24
			end
			if (is_mode && bank == gsd_pkg::BANK_EXT) begin
				ext_value <= s_addr;
				dll_on    <= 1'b1; // R8
				odt_on    <= 1'b1; // R23
			end
		end
	end

	// Burst column walk and impedance updates
	always_ff @(posedge clk) begin
		if (!rstn || !s_rstn) begin
			burst_on     <= 1'b0;
			beats_left   <= '0;
			col_base     <= '0;
			col_off      <= '0;
			col_valid    <= 1'b0;
			col_is_write <= 1'b0;
			col_addr     <= '0;
			imp_update   <= 1'b0;
		end else begin
			col_valid  <= 1'b0;
			imp_update <= is_ref | (is_nop & ~read_on); // R21
			if (is_rd || is_wr) begin
				burst_on     <= 1'b1;
				beats_left   <= 2'(gsd_pkg::BURST_LEN - 1); // R17
				col_base     <= s_addr[7:2]; // R18
				col_off      <= s_addr[1:0] + 2'h1;
				col_is_write <= is_wr;
				col_valid    <= 1'b1;
				col_addr     <= s_addr[7:0]; // R20
			end else if (rise && burst_on) begin
				col_valid  <= 1'b1;
				col_addr   <= {col_base, col_off}; // R18
				col_off    <= col_off + 2'h1; // R18
				beats_left <= beats_left - 2'h1;
				burst_on   <= (beats_left != 2'h1);
			end
		end
	end
endmodule

// [gsd_link_if.sv]
// Command and reset pins between the memory controller and the memory device.
// The bench joins both ends through one instance; no clocking block.
`timescale 1ns/100ps
interface gsd_link_if;
	logic        ck;
	logic        device_reset_pin_n;
	logic        cke;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [1:0]  bank_select;
	logic [11:0] addr;
	logic        dq_oe;

	modport ctrl (
		output ck, device_reset_pin_n, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
		input  dq_oe
	);
	modport dev (
		input  ck, device_reset_pin_n, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
		output dq_oe
	);
endinterface

// [gsd_link_props.sv]
// Checker on the command link between the controller and device ends.
// Assumes both ends share clk and rstn; link signals come in as plain inputs.
`timescale 1ns/100ps
module gsd_link_props (
	// System
	input wire logic        clk,
	input wire logic        rstn,
	// Link
	input wire logic        ck,
	input wire logic        device_reset_pin_n,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [1:0]  bank_select,
	input wire logic [11:0] addr,
	input wire logic        dq_oe
);
	logic [3:0] cmd_q;
	logic [7:0] since;
	wire logic [3:0] cmd    = {cs_n, ras_n, cas_n, we_n};
	wire logic       is_mrs = cmd == gsd_pkg::MODE_REGISTER_WRITE_CMD;
	wire logic       is_nop = cmd == gsd_pkg::NOP_CMD;
	wire logic       exe    = !is_nop && cmd != gsd_pkg::DESELECT_CMD;
	wire logic       start  = exe && cmd != cmd_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Cycles since the last command began
	always_ff @(posedge clk) begin
		cmd_q <= cmd;
		if (!rstn) begin
			since <= 8'hff;
		end else if (start) begin
			since <= 8'h00;
		end else if (since != 8'hff) begin
			since <= since + 8'h01;
		end
	end

	AST_DATA_QUIET: assert property (dq_oe == 1'b0)
		else $error("data bus driven");
	AST_QUIET_IN_RESET: assert property (!device_reset_pin_n |-> !cke && !exe)
		else $error("command or clock enable while device reset low");
	AST_MRS_ENABLED: assert property (is_mrs |-> cke && device_reset_pin_n)
		else $error("mode write without clock enable");
	AST_CMD_ONE_PERIOD: assert property (start |-> ##1 $stable(cmd)[*7] ##1 is_nop)
		else $error("command not one link period then no-op");
	AST_CMD_SPACING: assert property (start |-> since >= 8'h37)
		else $error("commands closer than seven link periods");
	AST_PRECHARGE_ALL_CMD_ALL: assert property (cmd == gsd_pkg::PRECHARGE_ALL_CMD |-> addr[8])
		else $error("precharge without all-bank bit");
	AST_BURST_ALIGNED: assert property ((cmd == gsd_pkg::READ_CMD ||
		cmd == gsd_pkg::WRITE_CMD) |-> addr[1:0] == 2'h0 && !addr[8])
		else $error("burst column not aligned");
	AST_MODE_FIELDS: assert property ((is_mrs && bank_select == gsd_pkg::BANK_MODE &&
		addr != gsd_pkg::DUMMY_MODE[11:0]) |-> addr[2:0] == gsd_pkg::BL4_CODE && !addr[3])
		else $error("mode write with bad burst fields");
	AST_RELEASE_ORDER: assert property ($rose(device_reset_pin_n) |->
		##[1:8] cke ##[1:8] (cmd == gsd_pkg::PRECHARGE_ALL_CMD))
		else $error("no enable and precharge after reset release");
	AST_STABLE_AT_RISE: assert property ($rose(ck) |-> $stable({cmd, bank_select, addr}))
		else $error("link pins change at link clock rise");
	AST_DUMMY_THEN_EXT: assert property ((start && is_mrs &&
		{bank_select, addr} == gsd_pkg::DUMMY_MODE) |-> ##56 (is_mrs && bank_select == 2'h1))
		else $error("extended write does not follow dummy write");
	AST_EXT_THEN_MODE: assert property ((start && is_mrs && bank_select == 2'h1) |->
		##56 (is_mrs && bank_select == 2'h0 && addr[gsd_pkg::DLL_RST_BIT]))
		else $error("mode write with loop reset does not follow extended write");
endmodule

// [gsd_pkg.sv]
// Shared constants for the graphics memory init link: timing, codes, fields, register map.
// Assumes a 20 MHz system clock on both ends and a link clock made by the controller.
package gsd_pkg;

	// Clock and link rate
	localparam int CLK_MHZ   = 20;
	localparam int LINK_HALF = 4;

	// Power-up timing in microseconds and system clock cycles
	localparam int T_RESET_US = 100;
	localparam int T_POWER_US = 200;
	localparam int T_IMP_US   = 20;
	localparam int RESET_CYC  = T_RESET_US * CLK_MHZ;
	localparam int POWER_CYC  = T_POWER_US * CLK_MHZ;
	localparam int IMP_CYC    = T_IMP_US * CLK_MHZ;

	// Timing in link clock cycles
	localparam int DLL_LOCK_CLK       = 20000;
	localparam int MODE_WRITE_CLK     = 6;
	localparam int PDN_AFTER_DLL_CLK  = 10;
	localparam int DLL_SELF_CLEAR_CLK = 16;

	// Command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] MODE_REGISTER_WRITE_CMD = 4'h0;
	localparam logic [3:0] AUTO_REFRESH_CMD        = 4'h1;
	localparam logic [3:0] PRECHARGE_ALL_CMD       = 4'h2;
	localparam logic [3:0] WRITE_CMD               = 4'h4;
	localparam logic [3:0] READ_CMD                = 4'h5;
	localparam logic [3:0] NOP_CMD                 = 4'h7;
	localparam logic [3:0] DESELECT_CMD            = 4'hf;

	// Bank select codes for mode writes
	localparam logic [1:0] BANK_MODE = 2'h0;
	localparam logic [1:0] BANK_EXT  = 2'h1;

	// Address and mode field layout
	localparam int         ADDR_W         = 12;
	localparam int         COL_W          = 8;
	localparam int         BL_LSB         = 0;
	localparam int         BURST_TYPE_BIT = 3;
	localparam int         RL_LSB         = 4;
	localparam int         TEST_BIT       = 7;
	localparam int         DLL_RST_BIT    = 8;
	localparam int         WL_LSB         = 9;
	localparam int         PRECHARGE_ALL_CMD_BIT     = 8;
	localparam int         EXT_DT_BIT     = 2;
	localparam logic [2:0] BL4_CODE       = 3'h2;
	localparam logic [13:0] DUMMY_MODE    = 14'h0221;
	localparam int         BURST_LEN      = 4;

	// Controller register map
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_MODE   = 8'h04;
	localparam logic [7:0] REG_EXT    = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_ACCESS = 8'h10;
	localparam int         CTRL_START   = 0;
	localparam int         CTRL_TERM    = 1;
	localparam int         CTRL_REWRITE = 2;
	localparam int         ACC_WRITE    = 12;

	typedef enum logic [7:0] {
		GSD_IDLE    = 8'h01,
		GSD_POWER   = 8'h02,
		GSD_RELEASE = 8'h04,
		GSD_CKE_UP  = 8'h08,
		GSD_ISSUE   = 8'h10,
		GSD_GAP     = 8'h20,
		GSD_LOCK    = 8'h40,
		GSD_READY   = 8'h80
	} gsd_state_t;

endpackage

// [test_graphics_sdram_init_mode_reg.sv]
// Testbench joining the controller and device ends of the memory init link.
// Assumes package, link interface, both ends and the checker are compiled first.
`timescale 1ns/100ps
module test_graphics_sdram_init_mode_reg;
	logic        clk, rstn, reg_wr, reg_rd, term, we;
	logic [7:0]  reg_addr, blk;
	logic [31:0] reg_wdata, reg_rdata, last_rd, mw, ew;
	logic [11:0] mode_value, ext_value;
	logic [2:0]  burst_len_code, read_lat, write_lat;
	logic        test_mode, dll_reset_busy, mode_illegal, dll_on, odt_on;
	logic        addr_term_full, dq_term_quarter, imp_update, col_valid, col_is_write;
	logic [7:0]  col_addr;
	logic [1:0]  bnk;
	logic        rd_d = 1'b0;
	logic        rd_run = 1'b0;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          imp_cnt = 0;
	int          k;
	logic [32:0] rq[$];
	logic [8:0]  cq[$];
	wire logic [39:0] dev_state = {mode_value, ext_value, burst_len_code, read_lat, write_lat,
		test_mode, dll_reset_busy, mode_illegal, dll_on, odt_on, addr_term_full, dq_term_quarter};

	gsd_link_if link ();
	gsd_ctrl #(.POWER_CYC(40), .DLL_LOCK_CLK(20)) gsd_ctrl_inst (.clk(clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link(link));
	gsd_dev #(.DLL_SELF_CLEAR_CLK(4)) gsd_dev_inst (.clk(clk), .rstn(rstn), .link(link),
		.mode_value(mode_value), .ext_value(ext_value), .burst_len_code(burst_len_code),
		.read_lat(read_lat), .write_lat(write_lat), .test_mode(test_mode),
		.dll_reset_busy(dll_reset_busy), .mode_illegal(mode_illegal), .dll_on(dll_on),
		.odt_on(odt_on), .addr_term_full(addr_term_full), .dq_term_quarter(dq_term_quarter),
		.imp_update(imp_update), .col_valid(col_valid), .col_is_write(col_is_write),
		.col_addr(col_addr));
	gsd_link_props gsd_link_props_inst (.clk(clk), .rstn(rstn), .ck(link.ck),
		.device_reset_pin_n(link.device_reset_pin_n), .cke(link.cke), .cs_n(link.cs_n),
		.ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
		.bank_select(link.bank_select), .addr(link.addr), .dq_oe(link.dq_oe));

	always #25 clk = ~clk;

	task automatic chk(input string nm, input logic [39:0] ex, input logic [39:0] got);
		cmp_count++;
		if (got !== ex) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] ex);
		rq.push_back({c, ex});
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		last_rd = reg_rdata;
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		last_rd = 32'h0;
		while (last_rd[11:4] !== 8'h80 && n < 400) begin
			rd(gsd_pkg::REG_STATUS, 1'b0, 32'h0);
			n++;
		end
		if (n == 400)
			chk("ready_wait", 40'h0, 40'h1);
	endtask

	function automatic logic [39:0] exp_dev(input logic [11:0] m, input logic [11:0] e);
		logic [11:0] s;
		s = {m[11:9], 1'b0, m[7:4], 1'b0, 3'h2};
		return {s, e, 3'h2, s[6:4], s[11:9], s[7], 4'h3, term, e[2]};
	endfunction

	// Results from the design, matched against the oldest note
	always @(posedge clk) begin
		if (rd_d && rq[0][32])
			chk("reg_rdata", {8'h0, rq[0][31:0]}, {8'h0, reg_rdata});
		if (rd_d)
			void'(rq.pop_front());
		rd_d <= reg_rd;
		if (col_valid && cq.size() == 0)
			chk("col_unexpected", 40'h0, 40'h1);
		else if (col_valid)
			chk("col_beat", {31'h0, cq.pop_front()}, {31'h0, col_is_write, col_addr});
		if (imp_update)
			imp_cnt++;
		if (imp_update && (rd_run || (col_valid && !col_is_write)) && col_addr[1:0] != 2'h3)
			chk("imp_in_read", 40'h0, 40'h1);
		if (col_valid && !col_is_write)
			rd_run <= col_addr[1:0] != 2'h3;
	end

	initial begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		conclude();
	end

	initial begin
		clk       = 1'b0;
		rstn      = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		void'($urandom(57));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		mw   = $urandom;
		ew   = $urandom;
		term = mw[31];
		rd(gsd_pkg::REG_STATUS, 1'b1, 32'h10);
		rd(8'h14, 1'b1, 32'h0);
		wr(8'h20, 32'hffff_ffff);
		rd(gsd_pkg::REG_CTRL, 1'b1, 32'h0);
		wr(gsd_pkg::REG_ACCESS, 32'h0);
		rd(gsd_pkg::REG_ACCESS, 1'b1, 32'h0);
		chk("dev_idle", 40'h10, dev_state);
		wr(gsd_pkg::REG_MODE, mw);
		wr(gsd_pkg::REG_EXT, ew);
		wr(gsd_pkg::REG_CTRL, {30'h0, term, 1'b1});
		wait_ready();
		chk("imp_updates", 40'h1, {39'h0, imp_cnt >= 2});
		rd(gsd_pkg::REG_STATUS, 1'b1, 32'h806);
		rd(gsd_pkg::REG_CTRL, 1'b1, {30'h0, term, 1'b0});
		rd(gsd_pkg::REG_MODE, 1'b1, {20'h0, mw[11:0]});
		rd(gsd_pkg::REG_EXT, 1'b1, {20'h0, ew[11:0]});
		chk("dev_init", exp_dev(mw[11:0], ew[11:0]), dev_state);
		mw = $urandom | 32'h100;
		wr(gsd_pkg::REG_MODE, mw);
		wr(gsd_pkg::REG_CTRL, {29'h0, 1'b1, term, 1'b0});
		k = 0;
		while (dll_reset_busy !== 1'b1 && k < 40) begin
			@(posedge clk);
			k++;
		end
		chk("dll_reset_seen", 40'h1, {39'h0, dll_reset_busy});
		wait_ready();
		chk("dev_rewrite", exp_dev(mw[11:0], ew[11:0]), dev_state);
		for (int i = 0; i < 4; i++) begin
			blk = 8'($urandom) & 8'hfc;
			bnk = 2'($urandom);
			we  = i[0];
			for (int j = 0; j < 4; j++)
				cq.push_back({we, blk[7:2], 2'(j)});
			wr(gsd_pkg::REG_ACCESS, {19'h0, we, 2'h0, bnk, blk[7:2], 2'h0});
			wr(gsd_pkg::REG_ACCESS, 32'h10fc);
			wait_ready();
			rd(gsd_pkg::REG_ACCESS, 1'b1, {19'h0, we, 2'h0, bnk, blk[7:2], 2'h0});
		end
		repeat (40) @(posedge clk);
		chk("beats_left", 40'h0, 40'(cq.size()));
		conclude();
	end
endmodule
